/* File: logic/mcrs_top.sv */
`timescale 1ns/1ps
`default_nettype none

// Contract
// RULE_01: fault output high while laser fault present
// RULE_02: laser-off high or open turns transmitter off
// RULE_03: laser-off pin also clears latched fault
// RULE_04: module-missing line tied to module ground
// RULE_05: signal-lost high when received power low
// RULE_06: both soft rate bits reset to zero
// RULE_07: undriven rate pins read as zero
// RULE_08: rx soft bit: byte 0x6e bit 3
// RULE_09: tx soft bit: byte 0x76 bit 3
// RULE_10: rate select is pin OR soft bit
// RULE_11: writing one selects maximum bandwidth
// RULE_12: fault clears on off pulse once gone
module mcrs_top
  import mcrs_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda,
  output logic o_sda_oe,
  input wire logic i_tx_off,
  input wire logic i_laser_fault,
  input wire logic i_rx_power_low,
  input wire logic i_rx_rate_pin,
  input wire logic i_tx_rate_pin,
  output logic o_tx_fault,
  output logic o_rx_signal_lost,
  output logic o_module_missing,
  output logic o_laser_on,
  output logic o_rx_retimer_engaged,
  output logic o_tx_retimer_engaged
);

  // --------------------------------------------------------------------
  // reset release
  // --------------------------------------------------------------------
  logic [1:0] rst_sync_reg; // release shifter, asserts at once
  logic rst_n; // synchronised reset for the rest of the block

  // reset asserts asynchronously and releases two edges later
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_reg[1];

  // --------------------------------------------------------------------
  // state of the serial slave and pin synchronisers
  // --------------------------------------------------------------------
  typedef struct packed {
    logic [MCRS_SYNC_W-1:0] sync1; // first stage, read by sync2 only
    logic [MCRS_SYNC_W-1:0] sync2; // second stage, safe to use
    logic scl_d; // previous serial clock, for edges
    logic sda_d; // previous serial data, for start and stop
    mcrs_state_t state; // slave sequencer
    logic [3:0] bits; // bit counter within a byte
    logic [7:0] shift; // shift register in both directions
    logic [7:0] ptr; // byte pointer, auto-increments
    logic rw; // read requested in the address byte
    logic sda_oe; // pulls serial data low when set
    logic rx_soft; // rx_rate_soft_bit
    logic tx_soft; // tx_rate_soft_bit
  } mcrs_top_t;

  mcrs_top_t top_reg; // registered state
  mcrs_top_t top_next; // next state

  logic [MCRS_SYNC_W-1:0] pins; // raw asynchronous pins
  logic scl; // synchronised serial clock
  logic sda; // synchronised serial data
  logic scl_rise; // serial clock rising edge
  logic scl_fall; // serial clock falling edge
  logic bus_start; // data falls while clock high
  logic bus_stop; // data rises while clock high
  logic [7:0] rd_byte; // byte addressed by the pointer

  // idle level of each synchronised lane: bus lines and laser-off rest high
  localparam logic [MCRS_SYNC_W-1:0] PIN_IDLE = MCRS_SYNC_W'((1 << MCRS_S_SCL)
    | (1 << MCRS_S_SDA) | (1 << MCRS_S_TXOFF));

  // pin bundle; pull-up and pull-downs sit outside, in the pad ring
  always_comb begin
    pins = '0;
    pins[MCRS_S_SCL] = i_scl;
    pins[MCRS_S_SDA] = i_sda;
    pins[MCRS_S_TXOFF] = i_tx_off; // RULE_02
    pins[MCRS_S_FAULT] = i_laser_fault;
    pins[MCRS_S_RXLOW] = i_rx_power_low;
    pins[MCRS_S_RXPIN] = i_rx_rate_pin; // RULE_07
    pins[MCRS_S_TXPIN] = i_tx_rate_pin; // RULE_07
  end

  // --------------------------------------------------------------------
  // read mux
  // --------------------------------------------------------------------
  // only the soft rate bits are implemented; other bytes read as zero
  always_comb begin
    rd_byte = MCRS_READ_IDLE;
    if (top_reg.ptr == MCRS_RX_RATE_OFS) begin
      rd_byte[MCRS_RATE_SOFT_BIT] = top_reg.rx_soft; // RULE_08
    end
    if (top_reg.ptr == MCRS_TX_RATE_OFS) begin
      rd_byte[MCRS_RATE_SOFT_BIT] = top_reg.tx_soft; // RULE_09
    end
  end

  // --------------------------------------------------------------------
  // serial slave
  // --------------------------------------------------------------------
  // data is sampled on clock rise and changed just after clock fall;
  // the two-flop delay costs margin, so clock must stay well below 100 MHz/8
  always_comb begin
    top_next = top_reg;
    top_next.sync1 = pins;
    top_next.sync2 = top_reg.sync1;
    scl = top_reg.sync2[MCRS_S_SCL];
    sda = top_reg.sync2[MCRS_S_SDA];
    top_next.scl_d = scl;
    top_next.sda_d = sda;
    scl_rise = scl & ~top_reg.scl_d;
    scl_fall = ~scl & top_reg.scl_d;
    bus_start = scl & top_reg.scl_d & top_reg.sda_d & ~sda;
    bus_stop = scl & top_reg.scl_d & ~top_reg.sda_d & sda;
    if (bus_stop) begin
      // stop ends any transfer and frees the line
      top_next.state = MCRS_IDLE;
      top_next.sda_oe = 1'b0;
    end else if (bus_start) begin
      // start or repeated start: expect an address byte
      top_next.state = MCRS_ADDR;
      top_next.bits = 4'h0;
      top_next.sda_oe = 1'b0;
    end else if (scl_rise) begin
      case (top_reg.state)
        MCRS_ADDR, MCRS_PTR, MCRS_WDATA: begin
          top_next.shift = {top_reg.shift[6:0], sda};
          top_next.bits = top_reg.bits + 4'h1;
        end
        MCRS_RDATA_ACK: begin
          // a not-acknowledge from the host ends the read
          if (sda) begin
            top_next.state = MCRS_IDLE;
          end
        end
        default: begin
        end
      endcase
    end else if (scl_fall) begin
      case (top_reg.state)
        MCRS_ADDR: begin
          if (top_reg.bits == MCRS_BYTE_BITS) begin
            // answer only our own address, ignore the rest of the bus
            if (top_reg.shift[7:1] == MCRS_DEV_ADDR) begin
              top_next.rw = top_reg.shift[0];
              top_next.state = MCRS_ADDR_ACK;
              top_next.sda_oe = 1'b1;
            end else begin
              top_next.state = MCRS_IDLE;
            end
          end
        end
        MCRS_PTR: begin
          if (top_reg.bits == MCRS_BYTE_BITS) begin
            top_next.ptr = top_reg.shift;
            top_next.state = MCRS_PTR_ACK;
            top_next.sda_oe = 1'b1;
          end
        end
        MCRS_WDATA: begin
          if (top_reg.bits == MCRS_BYTE_BITS) begin
            // a one selects maximum bandwidth for that direction
            if (top_reg.ptr == MCRS_RX_RATE_OFS) begin
              top_next.rx_soft = top_reg.shift[MCRS_RATE_SOFT_BIT]; // RULE_08 RULE_11
            end
            if (top_reg.ptr == MCRS_TX_RATE_OFS) begin
              top_next.tx_soft = top_reg.shift[MCRS_RATE_SOFT_BIT]; // RULE_09 RULE_11
            end
            top_next.ptr = top_reg.ptr + MCRS_PTR_STEP;
            top_next.state = MCRS_WDATA_ACK;
            top_next.sda_oe = 1'b1;
          end
        end
        MCRS_ADDR_ACK: begin
          top_next.bits = 4'h0;
          if (top_reg.rw) begin
            // first read byte comes from the current pointer
            top_next.shift = rd_byte;
            top_next.sda_oe = ~rd_byte[7];
            top_next.ptr = top_reg.ptr + MCRS_PTR_STEP;
            top_next.state = MCRS_RDATA;
          end else begin
            top_next.sda_oe = 1'b0;
            top_next.state = MCRS_PTR;
          end
        end
        MCRS_PTR_ACK, MCRS_WDATA_ACK: begin
          top_next.sda_oe = 1'b0;
          top_next.bits = 4'h0;
          top_next.state = MCRS_WDATA;
        end
        MCRS_RDATA: begin
          if (top_reg.bits == MCRS_LAST_BIT) begin
            // release the line for the host's acknowledge
            top_next.sda_oe = 1'b0;
            top_next.state = MCRS_RDATA_ACK;
          end else begin
            top_next.bits = top_reg.bits + 4'h1;
            top_next.shift = {top_reg.shift[6:0], 1'b0};
            top_next.sda_oe = ~top_reg.shift[6];
          end
        end
        MCRS_RDATA_ACK: begin
          // host acknowledged: stream the next byte
          top_next.bits = 4'h0;
          top_next.shift = rd_byte;
          top_next.sda_oe = ~rd_byte[7];
          top_next.ptr = top_reg.ptr + MCRS_PTR_STEP;
          top_next.state = MCRS_RDATA;
        end
        default: begin
          top_next.state = MCRS_IDLE;
        end
      endcase
    end
  end

  // state register; sync stages start at the pins' idle levels, since a
  // laser-off lane starting low would flash the laser just after reset
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      top_reg <= '0;
      top_reg.sync1 <= PIN_IDLE; // RULE_02
      top_reg.sync2 <= PIN_IDLE; // RULE_02
      top_reg.scl_d <= 1'b1;
      top_reg.sda_d <= 1'b1;
      top_reg.state <= MCRS_IDLE;
      top_reg.rx_soft <= MCRS_SOFT_RESET; // RULE_06
      top_reg.tx_soft <= MCRS_SOFT_RESET; // RULE_06
    end else begin
      top_reg <= top_next;
    end
  end

  // --------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------
  // open drain: the module only ever pulls the data line low
  assign o_sda = 1'b0;
  assign o_sda_oe = top_reg.sda_oe;

  // inserted module grounds this line; the host pull-up reads high if absent
  assign o_module_missing = 1'b0; // RULE_04

  // control core sees only synchronised pins
  mcrs_ctrl_core u_core (
    .i_clock(i_clock),
    .i_rst_n(rst_n),
    .i_tx_off(top_reg.sync2[MCRS_S_TXOFF]),
    .i_laser_fault(top_reg.sync2[MCRS_S_FAULT]),
    .i_rx_power_low(top_reg.sync2[MCRS_S_RXLOW]),
    .i_rx_rate_pin(top_reg.sync2[MCRS_S_RXPIN]),
    .i_tx_rate_pin(top_reg.sync2[MCRS_S_TXPIN]),
    .i_rx_rate_soft_bit(top_reg.rx_soft),
    .i_tx_rate_soft_bit(top_reg.tx_soft),
    .o_tx_fault(o_tx_fault),
    .o_rx_signal_lost(o_rx_signal_lost),
    .o_laser_on(o_laser_on),
    .o_rx_retimer_engaged(o_rx_retimer_engaged),
    .o_tx_retimer_engaged(o_tx_retimer_engaged)
  );

endmodule : mcrs_top

`default_nettype wire

/* File: common/mcrs_pkg.sv */
// ----------------------------------------------------------------------
// shared constants for the module control and rate select block
// ----------------------------------------------------------------------
package mcrs_pkg;

  // --------------------------------------------------------------------
  // two-wire management slave
  // --------------------------------------------------------------------
  localparam logic [6:0] MCRS_DEV_ADDR = 7'h51; // serial address a2h, 7-bit form
  localparam logic [7:0] MCRS_RX_RATE_OFS = 8'h6e; // rx_rate_soft_control byte
  localparam logic [7:0] MCRS_TX_RATE_OFS = 8'h76; // tx_rate_soft_control byte
  localparam int MCRS_RATE_SOFT_BIT = 3; // soft rate-select position in its byte
  localparam logic MCRS_SOFT_RESET = 1'h0; // soft bits leave reset cleared
  localparam logic [7:0] MCRS_READ_IDLE = 8'h00; // unmapped bytes and spare bits
  localparam logic [3:0] MCRS_BYTE_BITS = 4'h8; // bits per serial byte
  localparam logic [3:0] MCRS_LAST_BIT = 4'h7; // index of the last bit sent
  localparam logic [7:0] MCRS_PTR_STEP = 8'h01; // auto-increment of the byte pointer

  // --------------------------------------------------------------------
  // pin synchroniser lanes
  // --------------------------------------------------------------------
  localparam int MCRS_SYNC_W = 7; // number of pins brought into the clock domain
  localparam int MCRS_S_SCL = 0; // serial clock
  localparam int MCRS_S_SDA = 1; // serial data
  localparam int MCRS_S_TXOFF = 2; // laser-off pin
  localparam int MCRS_S_FAULT = 3; // laser fault detector
  localparam int MCRS_S_RXLOW = 4; // received power below threshold
  localparam int MCRS_S_RXPIN = 5; // rx_rate_pin
  localparam int MCRS_S_TXPIN = 6; // tx_rate_pin

  // serial slave states
  typedef enum logic [3:0] {
    MCRS_IDLE,
    MCRS_ADDR,
    MCRS_ADDR_ACK,
    MCRS_PTR,
    MCRS_PTR_ACK,
    MCRS_WDATA,
    MCRS_WDATA_ACK,
    MCRS_RDATA,
    MCRS_RDATA_ACK
  } mcrs_state_t;

endpackage : mcrs_pkg

/* File: logic/mcrs_ctrl_core.sv */
`timescale 1ns/1ps
`default_nettype none

// fault latch, laser enable, signal-lost and retimer mode selection
module mcrs_ctrl_core
  import mcrs_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_tx_off,
  input wire logic i_laser_fault,
  input wire logic i_rx_power_low,
  input wire logic i_rx_rate_pin,
  input wire logic i_tx_rate_pin,
  input wire logic i_rx_rate_soft_bit,
  input wire logic i_tx_rate_soft_bit,
  output logic o_tx_fault,
  output logic o_rx_signal_lost,
  output logic o_laser_on,
  output logic o_rx_retimer_engaged,
  output logic o_tx_retimer_engaged
);

  // --------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------
  typedef struct packed {
    logic fault; // latched transmitter fault
    logic off_seen; // laser-off level of the previous cycle
    logic los; // signal-lost output
    logic laser_on; // transmitter enable
    logic rx_eng; // rx_retimer engaged
    logic tx_eng; // tx_retimer engaged
  } mcrs_core_t;

  mcrs_core_t core_reg; // registered state
  mcrs_core_t core_next; // next state

  // next-state logic
  always_comb begin
    core_next = core_reg;
    core_next.off_seen = i_tx_off;
    core_next.laser_on = ~i_tx_off; // RULE_02
    core_next.los = i_rx_power_low; // RULE_05
    // falling edge of laser-off clears only a fault that has gone away
    if (core_reg.off_seen && !i_tx_off && !i_laser_fault) begin
      core_next.fault = 1'b0; // RULE_03 RULE_12
    end
    // a live fault wins over the clear in the same cycle
    if (i_laser_fault) begin
      core_next.fault = 1'b1; // RULE_01
    end
    core_next.rx_eng = i_rx_rate_pin | i_rx_rate_soft_bit; // RULE_10
    core_next.tx_eng = i_tx_rate_pin | i_tx_rate_soft_bit; // RULE_10
  end

  // state register; the laser stays dark through reset
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      core_reg <= '0;
    end else begin
      core_reg <= core_next;
    end
  end

  assign o_tx_fault = core_reg.fault;
  assign o_rx_signal_lost = core_reg.los;
  assign o_laser_on = core_reg.laser_on;
  assign o_rx_retimer_engaged = core_reg.rx_eng;
  assign o_tx_retimer_engaged = core_reg.tx_eng;

endmodule : mcrs_ctrl_core

`default_nettype wire

/* File: verification/mcrs_checker.sv */
`timescale 1ns/1ps
`default_nettype none
// --------------------------------------------------
// port-level checks of the control and rate block
// --------------------------------------------------
module mcrs_checker
  import mcrs_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_scl,
  input wire logic i_tx_off,
  input wire logic i_laser_fault,
  input wire logic i_rx_power_low,
  input wire logic i_rx_rate_pin,
  input wire logic i_tx_rate_pin,
  input wire logic o_sda_oe,
  input wire logic o_tx_fault,
  input wire logic o_rx_signal_lost,
  input wire logic o_module_missing,
  input wire logic o_laser_on,
  input wire logic o_rx_retimer_engaged,
  input wire logic o_tx_retimer_engaged
);
  logic [3:0] up_cnt_reg; // edges since release, stops at 8
  logic settled; // pin pipeline full of post-reset samples
  // count out the synchroniser fill so $past never sees reset
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      up_cnt_reg <= 4'h0;
    end else if (up_cnt_reg != 4'h8) begin
      up_cnt_reg <= up_cnt_reg + 4'h1;
    end
  end
  assign settled = (up_cnt_reg == 4'h8);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  laser_off_a: assert property (
    settled && $past(i_tx_off, 3) == $past(i_tx_off, 4) |-> o_laser_on == !$past(i_tx_off, 3))
    else $error("laser enable does not follow laser-off pin");
  sig_lost_a: assert property (
    settled && $past(i_rx_power_low, 3) == $past(i_rx_power_low, 4)
    |-> o_rx_signal_lost == $past(i_rx_power_low, 3))
    else $error("signal-lost output wrong");
  rx_pin_a: assert property (
    settled && $past(i_rx_rate_pin, 3) && $past(i_rx_rate_pin, 4) |-> o_rx_retimer_engaged)
    else $error("rx retimer not engaged by pin");
  tx_pin_a: assert property (
    settled && $past(i_tx_rate_pin, 3) && $past(i_tx_rate_pin, 4) |-> o_tx_retimer_engaged)
    else $error("tx retimer not engaged by pin");
  fault_set_a: assert property (
    settled && $past(i_laser_fault, 3) && $past(i_laser_fault, 4) |-> o_tx_fault)
    else $error("fault output low while fault present");
  fault_hold_a: assert property (
    settled && o_tx_fault && !(i_tx_off || $past(i_tx_off) || $past(i_tx_off, 2)
    || $past(i_tx_off, 3) || $past(i_tx_off, 4)) |=> o_tx_fault)
    else $error("fault cleared without laser-off pulse");
  fault_clear_a: assert property (
    settled && $fell(o_tx_fault) |-> !$past(i_laser_fault, 3))
    else $error("fault cleared while still present");
  missing_low_a: assert property (!o_module_missing)
    else $error("module-missing line not grounded");
  ack_edge_a: assert property (
    settled && $changed(o_sda_oe) |-> !$past(i_scl) && !$past(i_scl, 2))
    else $error("data driver moved while serial clock high");
endmodule : mcrs_checker
`default_nettype wire

/* File: verification/mcrs_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// --------------------------------------------------
// host board two-wire master
// --------------------------------------------------
module mcrs_host_model (
  input wire logic i_clock,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_low
);
  // both lines released, pull-ups hold them high
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end
  // move just after an edge; phases of 6 clocks beat the synchroniser
  task automatic step(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask : step
  // data set while clock low, sampled late in the high phase
  task automatic bit_io(input logic b, output logic s);
    o_sda_low = !b;
    step(6);
    o_scl = 1'b1;
    step(5);
    s = i_sda;
    step(1);
    o_scl = 1'b0;
  endtask : bit_io
  // start or repeated start: data falls while clock high
  task automatic start();
    o_sda_low = 1'b0;
    step(6);
    o_scl = 1'b1;
    step(6);
    o_sda_low = 1'b1;
    step(6);
    o_scl = 1'b0;
  endtask : start
  task automatic stop();
    o_sda_low = 1'b1;
    step(6);
    o_scl = 1'b1;
    step(6);
    o_sda_low = 1'b0;
    step(6);
  endtask : stop
  // byte and ninth bit; reading sends 8'hff, ack_in 1 means nack
  task automatic xfer(input logic [7:0] wr, input logic ack_in,
                      output logic [7:0] rd, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_io(wr[i], rd[i]);
    end
    bit_io(ack_in, ack);
  endtask : xfer
endmodule : mcrs_host_model
`default_nettype wire

/* File: verification/mcrs_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(name, exp, got) begin compares++; if ((got) !== (exp)) begin mismatches++; \
  $display("[ERR] %s expected %h seen %h", name, exp, got); end end
module mcrs_top_tb;
  import mcrs_pkg::*;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic tx_off = 1'b1; // open pin: module pull-up reads high
  logic laser_fault = 1'b0;
  logic rx_power_low = 1'b0;
  logic rx_pin = 1'b0; // open rate pins read low
  logic tx_pin = 1'b0;
  logic scl, sda_low, sda_oe, sda_out, sda_wire, ack;
  logic tx_fault, sig_lost, missing, laser_on, rx_eng, tx_eng, rx_soft, tx_soft, dir;
  logic [7:0] rd, rd2;
  logic [7:0] soft_mask = 8'h01 << MCRS_RATE_SOFT_BIT;
  int mismatches = 0;
  int compares = 0;
  always #5 clock = ~clock;
  // open-drain wire: low if anyone pulls, else pulled up
  assign sda_wire = !(sda_low || (sda_oe && !sda_out));
  mcrs_host_model host (.i_clock(clock), .i_sda(sda_wire), .o_scl(scl), .o_sda_low(sda_low));
  mcrs_top DUT (.i_clock(clock), .i_rst_n(rst_n), .i_scl(scl), .i_sda(sda_wire),
    .o_sda(sda_out), .o_sda_oe(sda_oe), .i_tx_off(tx_off), .i_laser_fault(laser_fault),
    .i_rx_power_low(rx_power_low), .i_rx_rate_pin(rx_pin), .i_tx_rate_pin(tx_pin),
    .o_tx_fault(tx_fault), .o_rx_signal_lost(sig_lost), .o_module_missing(missing),
    .o_laser_on(laser_on), .o_rx_retimer_engaged(rx_eng), .o_tx_retimer_engaged(tx_eng));
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick
  // device address and pointer phase shared by reads and writes
  task automatic point(input logic [7:0] ofs);
    logic [7:0] d;
    logic a0, a1;
    host.start();
    host.xfer({MCRS_DEV_ADDR, 1'b0}, 1'b1, d, a0);
    host.xfer(ofs, 1'b1, d, a1);
    `CHK("address acks", 2'b00, {a0, a1})
  endtask : point
  task automatic wr_reg(input logic [7:0] ofs, input logic [7:0] wd);
    logic [7:0] d;
    logic a;
    point(ofs);
    host.xfer(wd, 1'b1, d, a);
    host.stop();
    `CHK("data ack", 1'b0, a)
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] ofs, output logic [7:0] d);
    logic [7:0] x;
    logic a;
    point(ofs);
    host.start();
    host.xfer({MCRS_DEV_ADDR, 1'b1}, 1'b1, x, a);
    host.xfer(8'hff, 1'b1, d, a);
    host.stop();
  endtask : rd_reg
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : wrap_up
  // --------------------------------------------------
  // main sequence
  // --------------------------------------------------
  initial begin
    tick(6);
    rst_n = 1'b1;
    tick(6);
    `CHK("rx engaged", 1'b0, rx_eng)
    `CHK("laser on", 1'b0, laser_on)
    `CHK("module missing", 1'b0, missing)
    rd_reg(MCRS_RX_RATE_OFS, rd);
    `CHK("rx soft reset", MCRS_READ_IDLE, rd)
    rd_reg(MCRS_TX_RATE_OFS, rd);
    `CHK("tx soft reset", MCRS_READ_IDLE, rd)
    $display("test reset done");
    rx_soft = 1'b0;
    tx_soft = 1'b0;
    // both directions, every pin and soft combination
    for (int i = 0; i < 8; i++) begin
      dir = i[2];
      if (dir) tx_pin = i[1]; else rx_pin = i[1];
      if (dir) tx_soft = i[0]; else rx_soft = i[0];
      wr_reg(dir ? MCRS_TX_RATE_OFS : MCRS_RX_RATE_OFS, i[0] ? 8'hff : 8'h00);
      rd_reg(dir ? MCRS_TX_RATE_OFS : MCRS_RX_RATE_OFS, rd);
      `CHK("soft byte", i[0] ? soft_mask : MCRS_READ_IDLE, rd)
      `CHK("rx engaged", rx_pin | rx_soft, rx_eng)
      `CHK("tx engaged", tx_pin | tx_soft, tx_eng)
    end
    // unmapped byte and a foreign device address
    wr_reg(MCRS_RX_RATE_OFS + 8'h01, 8'hff);
    rd_reg(MCRS_RX_RATE_OFS + 8'h01, rd);
    `CHK("unmapped byte", MCRS_READ_IDLE, rd)
    host.start();
    host.xfer({MCRS_DEV_ADDR ^ 7'h01, 1'b0}, 1'b1, rd, ack);
    host.stop();
    `CHK("foreign ack", 1'b1, ack)
    // burst read across the tx byte, host acks the first byte
    point(MCRS_TX_RATE_OFS - 8'h01);
    host.start();
    host.xfer({MCRS_DEV_ADDR, 1'b1}, 1'b1, rd, ack);
    host.xfer(8'hff, 1'b0, rd, ack);
    host.xfer(8'hff, 1'b1, rd2, ack);
    host.stop();
    `CHK("burst first", MCRS_READ_IDLE, rd)
    `CHK("burst second", soft_mask, rd2)
    // burst write: spare byte, then the rx byte through the stepped pointer
    point(MCRS_RX_RATE_OFS - 8'h01);
    host.xfer(8'hff, 1'b1, rd, ack);
    host.xfer(8'h00, 1'b1, rd, ack);
    host.stop();
    `CHK("burst ack", 1'b0, ack)
    rd_reg(MCRS_RX_RATE_OFS, rd);
    `CHK("burst write", MCRS_READ_IDLE, rd)
    wr_reg(MCRS_RX_RATE_OFS, 8'hff);
    $display("test rate done");
    // fault latch: set, survive pulse while present, clear after
    tx_off = 1'b0;
    laser_fault = 1'b1;
    tick(5);
    `CHK("fault set", 1'b1, tx_fault)
    `CHK("laser on", 1'b1, laser_on)
    tx_off = 1'b1;
    tick(5);
    tx_off = 1'b0;
    tick(5);
    `CHK("fault kept", 1'b1, tx_fault)
    laser_fault = 1'b0;
    tick(5);
    `CHK("fault latched", 1'b1, tx_fault)
    tx_off = 1'b1;
    tick(5);
    `CHK("laser off", 1'b0, laser_on)
    tx_off = 1'b0;
    tick(5);
    `CHK("fault cleared", 1'b0, tx_fault)
    $display("test fault done");
    rx_power_low = 1'b1;
    tick(5);
    `CHK("signal lost", 1'b1, sig_lost)
    rx_power_low = 1'b0;
    tick(5);
    `CHK("signal back", 1'b0, sig_lost)
    // reset in mid-run drops both set soft bits
    rx_pin = 1'b0;
    tx_pin = 1'b0;
    rst_n = 1'b0;
    tick(2);
    rst_n = 1'b1;
    tick(6);
    `CHK("rx after reset", 1'b0, rx_eng)
    `CHK("tx after reset", 1'b0, tx_eng)
    $display("test signal and reset done");
    wrap_up();
  end
  // hang guard
  initial begin
    #900_000;
    mismatches++;
    wrap_up();
  end
endmodule : mcrs_top_tb
bind mcrs_top mcrs_checker u_chk (.i_clock, .i_rst_n, .i_scl, .i_tx_off, .i_laser_fault,
  .i_rx_power_low, .i_rx_rate_pin, .i_tx_rate_pin, .o_sda_oe, .o_tx_fault, .o_rx_signal_lost,
  .o_module_missing, .o_laser_on, .o_rx_retimer_engaged, .o_tx_retimer_engaged);
`default_nettype wire
